// File: bbd_pkg.sv
// How it works
// - Branch condition comes from opcode bits 11..8, short displacement from bits 7..0.
// - Short displacement is a signed byte count, applied only when condition holds.
// - Zero short displacement fetches one extension word as 16-bit displacement.
// - All-ones short displacement fetches two extension words as 32-bit displacement.
// - Branch to the next instruction therefore uses the 16-bit extension form.
// - Invert samples the chosen bit, then writes it back complemented, rest kept.
// - Zero flag set when sampled bit was zero; X, N, V, C untouched.
// - Data register destination is 32 bits wide, bit number modulo 32.
// - Memory destination is a byte read-modify-write, bit number modulo 8.
// - Bit zero is always the least significant operand bit.
// - Bit number comes from an extension word or from a named data register.
// - Static form: bits 15..8 are 00001000, 7..6 operation, 5..0 mode/register.
// - Dynamic form: bits 15..12 zero, register in 11..9, bit 8 set.
// - Only data-alterable destination modes are accepted.
// - Long size for data register, byte size for every memory mode.
// - Condition selector uses the fixed sixteen-code encoding on N, Z, V, C.
// - Displacement is added to the opcode address plus two.
// - Dynamic clear uses bit 8 set with the clear selector in bits 7..6.
package bbd_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_OPCODE = 8'h00;
	localparam logic [7:0] OFS_EXT0 = 8'h04;
	localparam logic [7:0] OFS_EXT1 = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0c;
	localparam logic [7:0] OFS_CCR = 8'h10;
	localparam logic [7:0] OFS_BITSRC = 8'h14;
	localparam logic [7:0] OFS_DEST = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h24;
	localparam logic [7:0] OFS_NPC = 8'h28;

	// ****************************************
	// Flag positions in the condition register
	// ****************************************
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_X = 4;

	// ****************************************
	// Status register fields and command register bit
	// ****************************************
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ILLEGAL = 2;
	localparam int ST_TAKEN = 3;
	localparam int ST_LONG = 4;
	localparam int ST_KIND = 5;
	localparam int ST_DREG = 8;
	localparam int ST_NEXT = 12;
	localparam int CMD_GO = 0;

	// ****************************************
	// Opcode encodings
	// ****************************************
	localparam logic [3:0] OPC_BRANCH = 4'h6;
	localparam logic [7:0] OPC_STATIC_HI = 8'h08;
	localparam logic [1:0] OPC_INV = 2'h1;
	localparam logic [1:0] OPC_CLR = 2'h2;
	localparam logic [2:0] COND_RSVD = 3'h0;
	localparam logic [7:0] DISP_WORD = 8'h00;
	localparam logic [7:0] DISP_LONG = 8'hff;
	localparam logic [2:0] MODE_DREG = 3'h0;
	localparam logic [2:0] MODE_AREG = 3'h1;
	localparam logic [2:0] MODE_EXT = 3'h7;
	localparam logic [2:0] REG_ABS_W = 3'h0;
	localparam logic [2:0] REG_ABS_L = 3'h1;
	localparam logic [31:0] PC_STEP = 32'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {S_IDLE, S_DECODE, S_FETCH, S_EXEC} bbd_state_e;
	typedef enum logic [1:0] {K_NONE, K_BRANCH, K_INV, K_CLR} bbd_kind_e;

	typedef struct packed {
		bbd_state_e st;
		bbd_kind_e kind;
		logic ack;
		logic [31:0] rdat;
		logic [15:0] op;
		logic [15:0] ext0;
		logic [15:0] ext1;
		logic [31:0] pc;
		logic [4:0] ccr;
		logic [31:0] bitsrc;
		logic [31:0] dest;
		logic [31:0] res;
		logic [31:0] npc;
		logic [31:0] disp;
		logic [4:0] bitnum;
		logic [1:0] nfetch;
		logic [1:0] fidx;
		logic islong;
		logic done;
		logic illegal;
		logic taken;
	} bbd_state_s;

endpackage : bbd_pkg

// File: bbd_cond_eval.sv
`timescale 1ns/100ps
module bbd_cond_eval (
	// Selector and flags
	input wire logic [3:0] cond_i,
	input wire logic [4:0] ccr_i,
	// Result
	output logic true_o
);

	logic n;
	logic z;
	logic v;
	logic c;

	assign n = ccr_i[bbd_pkg::CCR_N];
	assign z = ccr_i[bbd_pkg::CCR_Z];
	assign v = ccr_i[bbd_pkg::CCR_V];
	assign c = ccr_i[bbd_pkg::CCR_C];

	always_comb begin
		case (cond_i)
			4'h0: true_o = 1'b1;
			4'h1: true_o = 1'b0;
			4'h2: true_o = ~c & ~z;
			4'h3: true_o = c | z;
			4'h4: true_o = ~c;
			4'h5: true_o = c;
			4'h6: true_o = ~z;
			4'h7: true_o = z;
			4'h8: true_o = ~v;
			4'h9: true_o = v;
			4'ha: true_o = ~n;
			4'hb: true_o = n;
			4'hc: true_o = ~(n ^ v);
			4'hd: true_o = n ^ v;
			4'he: true_o = ~z & ~(n ^ v);
			4'hf: true_o = z | (n ^ v);
			default: true_o = 1'b0;
		endcase
	end

endmodule : bbd_cond_eval

// File: bbd_decoder.sv
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module bbd_decoder (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_sel

	// Data-alterable destinations only
	function automatic logic mode_ok(input logic [5:0] ea);
		logic ok;
		ok = 1'b1;
		if (ea[5:3] == bbd_pkg::MODE_AREG) begin
			ok = 1'b0;
		end else if (ea[5:3] == bbd_pkg::MODE_EXT) begin
			ok = (ea[2:0] == bbd_pkg::REG_ABS_W) || (ea[2:0] == bbd_pkg::REG_ABS_L);
		end
		return ok;
	endfunction : mode_ok

	function automatic logic [31:0] ext_bytes(input logic [1:0] n);
		return {29'h0, n, 1'b0};
	endfunction : ext_bytes

	// ****************************************
	// State
	// ****************************************
	bbd_pkg::bbd_state_s q;
	bbd_pkg::bbd_state_s d;
	logic cond_true;
	logic hit;
	logic go;
	logic [7:0] adr;
	logic [15:0] word;
	logic [31:0] opnd;
	logic [31:0] mask;
	logic [4:0] bn;
	logic sampled;
	logic [31:0] base;

	bbd_cond_eval u_cond (
		.cond_i(q.op[11:8]),
		.ccr_i(q.ccr),
		.true_o(cond_true)
	);

	assign adr = {wb_adr_i[7:2], 2'b00};
	assign hit = wb_cyc_i & wb_stb_i & ~q.ack;
	assign go = hit & wb_we_i & (adr == bbd_pkg::OFS_CMD) & wb_sel_i[0]
		& wb_dat_i[bbd_pkg::CMD_GO];
	assign word = (q.fidx == 2'h0) ? q.ext0 : q.ext1;
	assign bn = q.islong ? q.bitnum : {2'b00, q.bitnum[2:0]};
	assign mask = 32'h1 << bn;
	assign opnd = q.islong ? q.dest : {24'h0, q.dest[7:0]};
	assign sampled = |(opnd & mask);
	assign base = q.pc + bbd_pkg::PC_STEP;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		d.ack = 1'b0;
		if (hit) begin
			d.ack = 1'b1;
			d.rdat = 32'h0;
			if (wb_we_i) begin
				case (adr)
					bbd_pkg::OFS_OPCODE: d.op = 16'(merge_sel({16'h0, q.op}, wb_dat_i,
						wb_sel_i));
					bbd_pkg::OFS_EXT0: d.ext0 = 16'(merge_sel({16'h0, q.ext0}, wb_dat_i,
						wb_sel_i));
					bbd_pkg::OFS_EXT1: d.ext1 = 16'(merge_sel({16'h0, q.ext1}, wb_dat_i,
						wb_sel_i));
					bbd_pkg::OFS_PC: d.pc = merge_sel(q.pc, wb_dat_i, wb_sel_i);
					bbd_pkg::OFS_CCR: d.ccr = 5'(merge_sel({27'h0, q.ccr}, wb_dat_i,
						wb_sel_i));
					bbd_pkg::OFS_BITSRC: d.bitsrc = merge_sel(q.bitsrc, wb_dat_i, wb_sel_i);
					bbd_pkg::OFS_DEST: d.dest = merge_sel(q.dest, wb_dat_i, wb_sel_i);
					default: d.rdat = 32'h0;
				endcase
			end else begin
				case (adr)
					bbd_pkg::OFS_OPCODE: d.rdat = {16'h0, q.op};
					bbd_pkg::OFS_EXT0: d.rdat = {16'h0, q.ext0};
					bbd_pkg::OFS_EXT1: d.rdat = {16'h0, q.ext1};
					bbd_pkg::OFS_PC: d.rdat = q.pc;
					bbd_pkg::OFS_CCR: d.rdat = {27'h0, q.ccr};
					bbd_pkg::OFS_BITSRC: d.rdat = q.bitsrc;
					bbd_pkg::OFS_DEST: d.rdat = q.dest;
					bbd_pkg::OFS_STATUS: begin
						d.rdat[bbd_pkg::ST_BUSY] = (q.st != bbd_pkg::S_IDLE);
						d.rdat[bbd_pkg::ST_DONE] = q.done;
						d.rdat[bbd_pkg::ST_ILLEGAL] = q.illegal;
						d.rdat[bbd_pkg::ST_TAKEN] = q.taken;
						d.rdat[bbd_pkg::ST_LONG] = q.islong;
						d.rdat[bbd_pkg::ST_KIND +: 2] = q.kind;
						d.rdat[bbd_pkg::ST_DREG +: 3] = q.op[11:9];
						d.rdat[bbd_pkg::ST_NEXT +: 2] = q.nfetch;
					end
					bbd_pkg::OFS_RESULT: d.rdat = q.res;
					bbd_pkg::OFS_NPC: d.rdat = q.npc;
					default: d.rdat = 32'h0;
				endcase
			end
		end

		case (q.st)
			bbd_pkg::S_IDLE: begin
				if (go) begin
					d.st = bbd_pkg::S_DECODE;
					d.done = 1'b0;
					d.illegal = 1'b0;
					d.taken = 1'b0;
					d.fidx = 2'h0;
					d.nfetch = 2'h0;
					d.kind = bbd_pkg::K_NONE;
				end
			end
			bbd_pkg::S_DECODE: begin
				d.st = bbd_pkg::S_IDLE;
				d.islong = (q.op[5:3] == bbd_pkg::MODE_DREG);
				if (q.op[15:12] == bbd_pkg::OPC_BRANCH) begin
					d.islong = 1'b0;
					if (q.op[11:9] == bbd_pkg::COND_RSVD) begin
						d.illegal = 1'b1;
					end else begin
						d.kind = bbd_pkg::K_BRANCH;
						d.disp = {{24{q.op[7]}}, q.op[7:0]};
						d.st = bbd_pkg::S_EXEC;
						if (q.op[7:0] == bbd_pkg::DISP_WORD) begin
							d.nfetch = 2'h1;
							d.st = bbd_pkg::S_FETCH;
						end else if (q.op[7:0] == bbd_pkg::DISP_LONG) begin
							d.nfetch = 2'h2;
							d.st = bbd_pkg::S_FETCH;
						end
					end
				end else if (q.op[15:8] == bbd_pkg::OPC_STATIC_HI
						&& (q.op[7:6] == bbd_pkg::OPC_INV || q.op[7:6] == bbd_pkg::OPC_CLR)
						&& mode_ok(q.op[5:0])) begin
					d.kind = (q.op[7:6] == bbd_pkg::OPC_INV) ? bbd_pkg::K_INV : bbd_pkg::K_CLR;
					d.nfetch = 2'h1;
					d.st = bbd_pkg::S_FETCH;
				end else if (q.op[15:12] == 4'h0 && q.op[8]
						&& (q.op[7:6] == bbd_pkg::OPC_INV || q.op[7:6] == bbd_pkg::OPC_CLR)
						&& mode_ok(q.op[5:0])) begin
					d.kind = (q.op[7:6] == bbd_pkg::OPC_INV) ? bbd_pkg::K_INV : bbd_pkg::K_CLR;
					d.bitnum = q.bitsrc[4:0];
					d.st = bbd_pkg::S_EXEC;
				end else begin
					d.illegal = 1'b1;
				end
			end
			bbd_pkg::S_FETCH: begin
				d.fidx = q.fidx + 2'h1;
				if (q.kind == bbd_pkg::K_BRANCH) begin
					d.disp = (q.fidx == 2'h0) ? {{16{word[15]}}, word} : {q.disp[15:0], word};
				// upper byte of the extension must be zero
				end else if (word[15:8] != 8'h00) begin
					d.illegal = 1'b1;
				end else begin
					d.bitnum = word[4:0];
				end
				if (d.illegal) begin
					d.st = bbd_pkg::S_IDLE;
				end else if (d.fidx == q.nfetch) begin
					d.st = bbd_pkg::S_EXEC;
				end
			end
			bbd_pkg::S_EXEC: begin
				d.st = bbd_pkg::S_IDLE;
				d.done = 1'b1;
				d.npc = base + ext_bytes(q.nfetch);
				if (q.kind == bbd_pkg::K_BRANCH) begin
					if (cond_true) begin
						d.npc = base + q.disp;
						d.taken = 1'b1;
					end
				end else begin
					d.ccr[bbd_pkg::CCR_Z] = ~sampled;
					d.res = (q.kind == bbd_pkg::K_INV) ? (opnd ^ mask) : (opnd & ~mask);
				end
			end
			default: d.st = bbd_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_single;
		q.ack |=> !q.ack;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

	property p_word_form;
		q.st == bbd_pkg::S_DECODE && q.op[15:12] == bbd_pkg::OPC_BRANCH
			&& q.op[11:9] != bbd_pkg::COND_RSVD && q.op[7:0] == bbd_pkg::DISP_WORD
			|=> q.nfetch == 2'h1 && q.st == bbd_pkg::S_FETCH ##1 q.st == bbd_pkg::S_EXEC;
	endproperty
	a_word_form: assert property (p_word_form) else $error("word displacement not fetched");

	property p_long_form;
		q.st == bbd_pkg::S_DECODE && q.op[15:12] == bbd_pkg::OPC_BRANCH
			&& q.op[11:9] != bbd_pkg::COND_RSVD && q.op[7:0] == bbd_pkg::DISP_LONG
			|=> q.nfetch == 2'h2 ##2 q.st == bbd_pkg::S_EXEC
			&& q.disp == {q.ext0, q.ext1};
	endproperty
	a_long_form: assert property (p_long_form) else $error("long displacement wrong");

	property p_branch_taken;
		q.st == bbd_pkg::S_EXEC && q.kind == bbd_pkg::K_BRANCH && cond_true
			|=> q.taken && q.npc == $past(q.pc) + bbd_pkg::PC_STEP + $past(q.disp);
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken target wrong");

	property p_branch_not;
		q.st == bbd_pkg::S_EXEC && q.kind == bbd_pkg::K_BRANCH && !cond_true
			|=> !q.taken && q.npc == $past(base) + ext_bytes($past(q.nfetch));
	endproperty
	a_branch_not: assert property (p_branch_not) else $error("untaken branch moved");

	property p_zflag;
		q.st == bbd_pkg::S_EXEC && q.kind != bbd_pkg::K_BRANCH
			|=> q.ccr[bbd_pkg::CCR_Z] == !$past(sampled)
			&& q.ccr[bbd_pkg::CCR_X] == $past(q.ccr[bbd_pkg::CCR_X])
			&& q.ccr[1:0] == $past(q.ccr[1:0]) && q.ccr[3] == $past(q.ccr[3]);
	endproperty
	a_zflag: assert property (p_zflag) else $error("flag update wrong");

	property p_invert;
		q.st == bbd_pkg::S_EXEC && q.kind == bbd_pkg::K_INV |=> q.res == $past(opnd ^ mask);
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_clear;
		q.st == bbd_pkg::S_EXEC && q.kind == bbd_pkg::K_CLR
			|=> q.res == $past(opnd & ~mask) && !q.res[$past(bn)];
	endproperty
	a_clear: assert property (p_clear) else $error("clear result wrong");

	property p_byte_size;
		q.st == bbd_pkg::S_EXEC && q.kind != bbd_pkg::K_BRANCH && !q.islong
			|=> q.res[31:8] == 24'h0;
	endproperty
	a_byte_size: assert property (p_byte_size) else $error("memory result not a byte");

	property p_illegal_mode;
		q.st == bbd_pkg::S_DECODE && q.op[15:12] == 4'h0 && !mode_ok(q.op[5:0])
			|=> q.illegal && q.st == bbd_pkg::S_IDLE && q.res == $past(q.res);
	endproperty
	a_illegal_mode: assert property (p_illegal_mode) else $error("bad mode executed");

endmodule : bbd_decoder

// File: test_branch_and_bit_op_decode.sv
`timescale 1ns/100ps
module test_branch_and_bit_op_decode;

	// ****************************************
	// Bench signals
	// ****************************************
	localparam logic [31:0] PC0 = 32'h0000_1000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	int n_errors = 0;
	int check_count = 0;
	logic [15:0] ill_op [8] = '{16'h0848, 16'h087c, 16'h087a, 16'h087b, 16'h0149, 16'h0850,
		16'h6080, 16'h6180};
	logic [5:0] mem_ea [7] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h39};

	bbd_decoder i_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o)
	);

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Request held until ack is sampled, then released for one idle cycle
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t no acknowledge", $time);
			stop_test();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, adr, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] adr, output logic [31:0] d);
		bus(1'b0, adr, 32'h0, d);
	endtask : rd

	task automatic exec_op(input logic [15:0] op, input logic [15:0] e0, input logic [15:0] e1,
			input logic [31:0] bs, input logic [31:0] ds, input logic [4:0] cc);
		logic [31:0] s;
		int n;
		wr(bbd_pkg::OFS_OPCODE, {16'h0, op});
		wr(bbd_pkg::OFS_EXT0, {16'h0, e0});
		wr(bbd_pkg::OFS_EXT1, {16'h0, e1});
		wr(bbd_pkg::OFS_PC, PC0);
		wr(bbd_pkg::OFS_CCR, {27'h0, cc});
		wr(bbd_pkg::OFS_BITSRC, bs);
		wr(bbd_pkg::OFS_DEST, ds);
		wr(bbd_pkg::OFS_CMD, 32'h1);
		n = 0;
		do begin
			rd(bbd_pkg::OFS_STATUS, s);
			n++;
		// Illegal opcodes end without done, so either flag ends the wait
		end while ((s[bbd_pkg::ST_BUSY] !== 1'b0
				|| (s[bbd_pkg::ST_DONE] | s[bbd_pkg::ST_ILLEGAL]) !== 1'b1) && n < 20);
		if (s[bbd_pkg::ST_BUSY] !== 1'b0 || (s[bbd_pkg::ST_DONE] | s[bbd_pkg::ST_ILLEGAL]) !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t status poll expired", $time);
			stop_test();
		end
	endtask : exec_op

	function automatic logic [31:0] st_exp(input logic [15:0] op, input logic tk,
			input logic lg, input logic [1:0] kd, input logic [1:0] nx);
		return {18'h0, nx, 1'b0, op[11:9], 1'b0, kd, lg, tk, 3'b010};
	endfunction : st_exp

	// Branch size flag left open, so branches mask it out
	task automatic chk_out(input logic [31:0] st, input logic [31:0] m, input logic [31:0] npc,
			input logic [31:0] res, input logic [4:0] cc, input logic bit_op);
		logic [31:0] v;
		rd(bbd_pkg::OFS_STATUS, v);
		chk(v & m, st, "status");
		rd(bbd_pkg::OFS_NPC, v);
		chk(v, npc, "next pc");
		rd(bbd_pkg::OFS_CCR, v);
		chk(v, {27'h0, cc}, "flags");
		if (bit_op) begin
			rd(bbd_pkg::OFS_RESULT, v);
			chk(v, res, "result");
		end
	endtask : chk_out

	function automatic logic tb_cond(input logic [3:0] c, input logic [3:0] f);
		logic n, z, v, cy;
		{n, z, v, cy} = f;
		case (c)
			4'h2: return !cy && !z;
			4'h3: return cy || z;
			4'h4: return !cy;
			4'h5: return cy;
			4'h6: return !z;
			4'h7: return z;
			4'h8: return !v;
			4'h9: return v;
			4'ha: return !n;
			4'hb: return n;
			4'hc: return n == v;
			4'hd: return n != v;
			4'he: return n == v && !z;
			default: return z || n != v;
		endcase
	endfunction : tb_cond

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] v;
		logic [15:0] op;
		logic tk;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(bbd_pkg::OFS_STATUS, v);
		chk(v, 32'h0, "status after reset");
		wr(8'h30, 32'hffff_ffff);
		rd(8'h30, v);
		chk(v, 32'h0, "unmapped");
		for (int c = 2; c < 16; c++) begin
			for (int k = 0; k < 16; k++) begin
				op = {4'h6, c[3:0], 8'h80};
				tk = tb_cond(c[3:0], k[3:0]);
				exec_op(op, 16'h0, 16'h0, 32'h0, 32'h0, {1'b0, k[3:0]});
				chk_out(st_exp(op, tk, 1'b0, 2'h1, 2'h0), 32'h376f, tk ? 32'h0f82 : 32'h1002,
						32'h0, {1'b0, k[3:0]}, 1'b0);
			end
		end
		for (int z = 0; z < 2; z++) begin
			exec_op(16'h6700, 16'hfffe, 16'h0, 32'h0, 32'h0, {2'b0, z[0], 2'b0});
			chk_out(st_exp(16'h6700, z[0], 1'b0, 2'h1, 2'h1), 32'h376f, z ? PC0 : 32'h1004,
					32'h0, {2'b0, z[0], 2'b0}, 1'b0);
			exec_op(16'h67ff, 16'hffff, 16'hfffc, 32'h0, 32'h0, {2'b0, z[0], 2'b0});
			chk_out(st_exp(16'h67ff, z[0], 1'b0, 2'h1, 2'h2), 32'h376f, z ? 32'h0ffe : 32'h1006,
					32'h0, {2'b0, z[0], 2'b0}, 1'b0);
		end
		exec_op(16'h67ff, 16'h0001, 16'h8000, 32'h0, 32'h0, 5'h04);
		chk_out(st_exp(16'h67ff, 1'b1, 1'b0, 2'h1, 2'h2), 32'h376f, 32'h0001_9002, 32'h0, 5'h04,
				1'b0);
		exec_op(16'h6700, 16'h0002, 16'h0, 32'h0, 32'h0, 5'h04);
		chk_out(st_exp(16'h6700, 1'b1, 1'b0, 2'h1, 2'h1), 32'h376f, 32'h1004, 32'h0, 5'h04,
				1'b0);
		exec_op(16'h0840, 16'h0021, 16'h0, 32'h0, 32'h2, 5'h1b);
		chk_out(st_exp(16'h0840, 1'b0, 1'b1, 2'h2, 2'h1), 32'h377f, 32'h1004, 32'h0, 5'h1b,
				1'b1);
		exec_op(16'h0840, 16'h001f, 16'h0, 32'h0, 32'h0, 5'h00);
		chk_out(st_exp(16'h0840, 1'b0, 1'b1, 2'h2, 2'h1), 32'h377f, 32'h1004, 32'h8000_0000,
				5'h04, 1'b1);
		exec_op(16'h0890, 16'h000b, 16'h0, 32'h0, 32'h1234_56f7, 5'h1b);
		chk_out(st_exp(16'h0890, 1'b0, 1'b0, 2'h3, 2'h1), 32'h377f, 32'h1004, 32'h0000_00f7,
				5'h1f, 1'b1);
		exec_op(16'h0759, 16'h0, 16'h0, 32'h0f, 32'h80, 5'h00);
		chk_out(st_exp(16'h0759, 1'b0, 1'b0, 2'h2, 2'h0), 32'h377f, 32'h1002, 32'h0, 5'h00,
				1'b1);
		exec_op(16'h0585, 16'h0, 16'h0, 32'h3f, 32'hffff_ffff, 5'h04);
		chk_out(st_exp(16'h0585, 1'b0, 1'b1, 2'h3, 2'h0), 32'h377f, 32'h1002, 32'h7fff_ffff,
				5'h00, 1'b1);
		foreach (mem_ea[i]) begin
			op = {10'h006, mem_ea[i]};
			exec_op(op, 16'h0, 16'h0, 32'h9, 32'h1ff, 5'h1f);
			chk_out(st_exp(op, 1'b0, 1'b0, 2'h3, 2'h0), 32'h377f, 32'h1002, 32'h0000_00fd, 5'h1b,
					1'b1);
		end
		foreach (ill_op[i]) begin
			exec_op(ill_op[i], (i == 5) ? 16'h0100 : 16'h0001, 16'h0, 32'h1, 32'h0, 5'h1f);
			rd(bbd_pkg::OFS_STATUS, v);
			chk(v & 32'h7, 32'h4, "illegal flag");
			rd(bbd_pkg::OFS_CCR, v);
			chk(v, 32'h1f, "flags after illegal");
		end
		stop_test();
	end

	// Whole run needs about 9000 cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		n_errors++;
		$display("FAIL %0t watchdog expired", $time);
		stop_test();
	end

endmodule : test_branch_and_bit_op_decode
